// *** src/ipc_ctrl.v ***
// Interrupt priority controller: flags, enables, levels, arbitration, vectors
`timescale 1ns/100ps
`include "ipc_map.vh"

// What this block does
// - Arbitrate 54 sources and 4 traps by priority
// - Vector loads PC via 24-bit path
// - Tables start at addresses 0x000004 and 0x000084
// - Hardware sets flags, only software clears
// - Flags set regardless of enable bit
// - Request needs its enable bit set
// - Writable priority per 41 entries
// - CPU level four bits, split across registers
// - Source levels 1 to 7, seven highest
// - Level zero never interrupts
// - Nesting disable blocks new interrupts while servicing
// - Level bits read-only while nesting disabled
// - Trap flags and table select controls
// - Timed disable blocks levels six and below
// - PC loaded from the source's vector entry
// - 63 entries from 0x000004 to 0x0000FE
// - Plain (non-vector) fetch from vector space raises address trap
// - Jump into vector space raises address trap
// - Natural order only breaks equal-level ties
// - Number 0 highest, 53 lowest
module ipc_ctrl #(
    parameter NSRC = `IPC_NUM_SRC,
    parameter NPRI = `IPC_NUM_PRI
) (
    input  wire                  core_clk_i,
    input  wire                  nrst_i,
    input  wire [NSRC-1:0]       src_event_i,      // One-cycle request events
    input  wire [NSRC-1:0]       flag_clr_i,       // Software clear strobes
    input  wire [NSRC-1:0]       enable_i,         // Per-source enable bits
    input  wire                  pri_wr_i,         // Priority write strobe
    input  wire [5:0]            pri_idx_i,        // Entry being written
    input  wire [2:0]            pri_val_i,        // Level written
    input  wire                  ipl_wr_i,         // CPU level write strobe
    input  wire [3:0]            ipl_val_i,        // CPU level written
    input  wire                  nesting_disable_i,
    input  wire                  alt_table_sel_i,
    input  wire [`IPC_NUM_TRAP-1:0] trap_event_i,  // Trap sources, 0 highest
    input  wire [`IPC_NUM_TRAP-1:0] trap_clr_i,
    input  wire                  timed_disable_start_i,     // Timed disable issued
    input  wire [13:0]           timed_disable_count_i,
    input  wire                  instr_retire_i,   // One instruction done
    input  wire                  ack_i,            // Core takes the request
    input  wire                  service_done_i,   // Return from interrupt
    input  wire [`IPC_PC_W-1:0]  fetch_pc_i,
    input  wire                  fetch_valid_i,
    input  wire                  vector_fetch_i,   // Fetch is a vector read
    input  wire                  goto_valid_i,
    input  wire [`IPC_PC_W-1:0]  goto_target_i,
    input  wire                  vec_wr_i,         // Vector table loader
    input  wire [6:0]            vec_wr_addr_i,
    input  wire [`IPC_PC_W-1:0]  vec_wr_data_i,
    output reg  [NSRC-1:0]       flags_o,
    output reg  [3:0]            cpu_priority_level_o,
    output reg  [`IPC_NUM_TRAP-1:0] trap_flags_o,
    output wire                  timed_disable_active_o,
    output reg                   irq_o,
    output reg  [5:0]            irq_num_o,
    output reg  [3:0]            irq_lvl_o,
    output reg                   pc_load_o,
    output reg  [`IPC_PC_W-1:0]  pc_vector_o
);
    // Request flags and levels
    reg  [NSRC-1:0]  flag_next;
    reg  [3*NPRI-1:0] pri_reg;
    reg  [13:0]      timed_disable_cnt_reg;
    reg              in_service_reg;
    reg  [5:0]       take_vec_reg;     // Vector number being fetched
    reg              fetch_pend_reg;   // Memory read outstanding
    wire [`IPC_PC_W-1:0] mem_rd;

    // Priority of one source, zero for unimplemented entries
    function [2:0] src_pri;
        input [5:0] n;
        input [3*NPRI-1:0] p;
        begin
            if (n < NPRI) begin
                src_pri = p[n*3 +: 3];
            end else begin
                src_pri = 3'h0;
            end
        end
    endfunction

    // Address inside vector space
    function in_vec_space;
        input [`IPC_PC_W-1:0] a;
        begin
            in_vec_space = (a >= `IPC_VEC_BASE) && (a <= `IPC_VEC_END);
        end
    endfunction

    // Vector number of a presented request.
    // Traps carry their index in the inverted low bits of their level,
    // so the vector follows the level that was presented and taken,
    // not whatever the arbiter sees in a later cycle.
    // Sources sit a fixed distance above the trap vectors.
    function [5:0] vec_of;
        input [3:0] lvl;
        input [5:0] num;
        begin
            if (lvl >= `IPC_LVL_NMI_BASE) begin
                vec_of = {4'h0, ~lvl[1:0]} + 6'h01;
            end else begin
                vec_of = num + `IPC_FIRST_IRQ_VEC;
            end
        end
    endfunction

    // Flag update: set wins over clear
    // An event and a clear strobe in the same cycle leave the flag set,
    // so a request that arrives while software is clearing the previous
    // one is never lost. Events are counted as levels: a source that
    // holds its event high keeps re-arming its flag every cycle.
    always @* begin
        flag_next = (flags_o & ~flag_clr_i) | src_event_i;
    end

    // Flag registers
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flags_o <= {NSRC{1'b0}};
        end else begin
            flags_o <= flag_next;
        end
    end

    // Priority entries, writable per entry
    // Three bits per entry, packed side by side. Writes to an index
    // beyond the implemented entries are dropped, and sources above
    // that index read as level zero, which keeps them out of arbitration.
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pri_reg <= {NPRI{`IPC_PRI_RST}};
        end else if (pri_wr_i && (pri_idx_i < NPRI)) begin
            pri_reg[pri_idx_i*3 +: 3] <= pri_val_i;
        end
    end

    // Address error detection
    // A plain fetch inside vector space means the program counter ran
    // somewhere it should never be; vector reads by the core itself are
    // excused. A jump whose target lands in the table is caught as well.
    wire addr_err = (fetch_valid_i && !vector_fetch_i && in_vec_space(fetch_pc_i))
                  || (goto_valid_i && in_vec_space(goto_target_i));

    // Trap flags: set wins over clear
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trap_flags_o <= {`IPC_NUM_TRAP{1'b0}};
        end else begin
            trap_flags_o <= (trap_flags_o & ~trap_clr_i) | trap_event_i
                          | ({{(`IPC_NUM_TRAP-1){1'b0}}, addr_err} << `IPC_TRAP_ADDRERR);
        end
    end

    // Timed disable countdown
    // Loaded by the timed disable instruction, counted down once per
    // retired instruction, and stopped at zero. A new start reloads it
    // even while a previous count is still running.
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timed_disable_cnt_reg <= 14'h0000;
        end else if (timed_disable_start_i) begin
            timed_disable_cnt_reg <= timed_disable_count_i;
        end else if (instr_retire_i && (timed_disable_cnt_reg != 14'h0000)) begin
            timed_disable_cnt_reg <= timed_disable_cnt_reg - 14'h0001;
        end
    end

    assign timed_disable_active_o = (timed_disable_cnt_reg != 14'h0000);

    // Arbitration of traps and sources
    // Traps always outrank maskable sources: their levels sit above the
    // highest source level. Among sources the highest assigned level wins,
    // and equal levels fall to the lowest interrupt number. The winner is
    // then held against the CPU level, the timed disable floor and the
    // nesting lock before it may be presented.
    reg       best_found;
    reg [5:0] best_num;
    reg [2:0] best_pri;
    reg       trap_found;
    reg [1:0] trap_num;
    reg [3:0] cand_lvl;
    reg       cand_ok;
    integer   i;
    always @* begin
        best_found = 1'b0;
        best_num   = 6'h00;
        best_pri   = 3'h0;
        trap_found = 1'b0;
        trap_num   = 2'h0;
        // Traps ahead of sources, lowest trap first
        for (i = `IPC_NUM_TRAP - 1; i >= 0; i = i - 1) begin
            if (trap_flags_o[i]) begin
                trap_found = 1'b1;
                trap_num   = i[1:0];
            end
        end
        // Scan from 53 down so lower numbers win ties
        for (i = NSRC - 1; i >= 0; i = i - 1) begin
            // Equal or higher level replaces, so an equal level ends on the lower number
            if (flags_o[i] && enable_i[i] && (src_pri(i[5:0], pri_reg) != 3'h0)
                && (src_pri(i[5:0], pri_reg) >= best_pri)) begin
                best_found = 1'b1;
                best_num   = i[5:0];
                best_pri   = src_pri(i[5:0], pri_reg);
            end
        end
        // Levels 1..7 compared as plain numbers
        cand_lvl = trap_found ? (`IPC_LVL_NMI_BASE + {2'b00, ~trap_num}) : {1'b0, best_pri};
        cand_ok  = (trap_found || best_found) && (cand_lvl > cpu_priority_level_o);
        // Timed disable masks levels six and below
        if (timed_disable_active_o && (cand_lvl <= `IPC_TIMED_DISABLE_MAX_LVL)) begin
            cand_ok = 1'b0;
        end
        // No new processing while servicing with nesting off
        if (nesting_disable_i && in_service_reg) begin
            cand_ok = 1'b0;
        end
    end

    // Request presented to the core
    // The request drops in the cycle after it is taken and stays down
    // while the vector is being fetched, so the core never sees a second
    // request before the first has loaded its vector.
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_o     <= 1'b0;
            irq_num_o <= 6'h00;
            irq_lvl_o <= 4'h0;
        end else begin
            irq_o     <= cand_ok && !ack_i && !fetch_pend_reg;
            irq_num_o <= best_num;
            irq_lvl_o <= cand_lvl;
        end
    end

    // CPU level: written by software, raised on acknowledge
    // Taking a request lifts the CPU level to the level of that request,
    // which masks equal and lower requests during its service. A software
    // write in the same cycle as a take loses to the take.
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cpu_priority_level_o <= 4'h0;
        end else if (ack_i && irq_o) begin
            cpu_priority_level_o <= irq_lvl_o;
        end else if (ipl_wr_i && !nesting_disable_i) begin
            // Four-bit level, split in software view
            cpu_priority_level_o <= ipl_val_i;
        end
    end

    // Service tracking and vector fetch sequencing
    // The vector number is captured from the presented level and number
    // at the edge on which the core takes the request.
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            in_service_reg <= 1'b0;
            fetch_pend_reg <= 1'b0;
            take_vec_reg   <= 6'h00;
        end else begin
            fetch_pend_reg <= ack_i && irq_o;
            if (ack_i && irq_o) begin
                in_service_reg <= 1'b1;
                take_vec_reg   <= vec_of(irq_lvl_o, irq_num_o);
            end else if (service_done_i) begin
                in_service_reg <= 1'b0;
            end
        end
    end

    // Tables start at 0x000004; word index = vector number
    // Alternate table in upper half of store
    // The store read is issued on the taking edge itself, so its
    // registered output already holds the vector one edge later, when
    // the load pulse is launched. Later cycles keep the captured number.
    wire       take_now    = ack_i && irq_o;   // Request taken at this edge
    wire [5:0] rd_vec      = take_now ? vec_of(irq_lvl_o, irq_num_o) : take_vec_reg;
    wire [6:0] vec_rd_addr = {alt_table_sel_i, rd_vec};

    ipc_vec_mem #(
        .AW (7),
        .DW (`IPC_PC_W)
    ) u_vec_mem (
        .core_clk_i (core_clk_i),
        .wr_en_i    (vec_wr_i),
        .wr_addr_i  (vec_wr_addr_i),
        .wr_data_i  (vec_wr_data_i),
        .rd_addr_i  (vec_rd_addr),
        .rd_data_o  (mem_rd)
    );

    // PC load path from the vector store
    // The load pulse lasts one cycle and carries the vector word beside it;
    // the core must take the address in that cycle.
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pc_load_o   <= 1'b0;
            pc_vector_o <= 24'h000000;
        end else begin
            pc_load_o   <= fetch_pend_reg;
            pc_vector_o <= mem_rd;
        end
    end
endmodule // ipc_ctrl

// *** pkg/ipc_map.vh ***
// Constants for the interrupt priority controller
`ifndef IPC_MAP_VH
`define IPC_MAP_VH
`define IPC_NUM_SRC        54
`define IPC_NUM_PRI        41
`define IPC_NUM_TRAP       4
`define IPC_PC_W           24
`define IPC_VEC_BASE       24'h000004
`define IPC_VEC_END        24'h0000FE
`define IPC_VEC_ENTRIES    63
`define IPC_ALT_OFFSET     24'h000080
`define IPC_FIRST_IRQ_VEC  6'h08
`define IPC_TIMED_DISABLE_MAX_LVL   4'h6
`define IPC_LVL_NMI_BASE   4'h8
`define IPC_ECR_NESTING_DISABLE     15
`define IPC_GCR2_TIMED_DISABLE      14
`define IPC_GCR2_ALTIVT    15
`define IPC_ECR_ADDRERR    3
`define IPC_TRAP_ADDRERR   2
`define IPC_FLAG_RST       16'h0000
`define IPC_PRI_RST        3'h4
`endif

// *** src/ipc_vec_mem.v ***
// Vector table store: 128 words of 24 bits, registered read
`timescale 1ns/100ps
module ipc_vec_mem #(
    parameter AW = 7,
    parameter DW = 24
) (
    input  wire          core_clk_i,
    input  wire          wr_en_i,
    input  wire [AW-1:0] wr_addr_i,
    input  wire [DW-1:0] wr_data_i,
    input  wire [AW-1:0] rd_addr_i,
    output reg  [DW-1:0] rd_data_o
);
    // Storage array
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Write port and registered read port
    always @(posedge core_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule // ipc_vec_mem

// *** test/ipc_ctrl_chk.sv ***
// Port-level property checker for the interrupt priority controller
`timescale 1ns/100ps
module ipc_ctrl_chk #(
    parameter NSRC = 54
) (
    input logic            core_clk_i,
    input logic            nrst_i,
    input logic [NSRC-1:0] src_event_i,
    input logic [NSRC-1:0] flag_clr_i,
    input logic [NSRC-1:0] flags_o,
    input logic            ipl_wr_i,
    input logic [3:0]      ipl_val_i,
    input logic            nesting_disable_i,
    input logic            ack_i,
    input logic            service_done_i,
    input logic            fetch_valid_i,
    input logic            vector_fetch_i,
    input logic [23:0]     fetch_pc_i,
    input logic [3:0]      cpu_priority_level_o,
    input logic [3:0]      trap_flags_o,
    input logic            timed_disable_active_o,
    input logic            irq_o,
    input logic [3:0]      irq_lvl_o,
    input logic            pc_load_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    // Flags: set by events next cycle, fall only when cleared
    property p_flag_set; src_event_i != 0 |=> (flags_o & $past(src_event_i)) == $past(src_event_i); endproperty
    a_flag_set: assert property (p_flag_set) else $error("event lost");
    property p_flag_hold; 1'b1 |=> ($past(flags_o) & ~flags_o & ~$past(flag_clr_i)) == 0; endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag fell uncleared");
    // Presented level must beat the CPU level, and the timed disable floor
    property p_above_cpu; $rose(irq_o) |-> irq_lvl_o > $past(cpu_priority_level_o); endproperty
    a_above_cpu: assert property (p_above_cpu) else $error("level not above cpu");
    property p_timed_disable; $past(timed_disable_active_o) && $rose(irq_o) |-> irq_lvl_o > 4'h6; endproperty
    a_timed_disable: assert property (p_timed_disable) else $error("low level during timed disable");
    // Taken request loads its vector two cycles later
    property p_vec_load; ack_i && irq_o |-> ##2 pc_load_o; endproperty
    a_vec_load: assert property (p_vec_load) else $error("no vector load");
    // CPU level writes: honoured, or ignored while nesting is disabled
    property p_ipl_ro; nesting_disable_i && ipl_wr_i && !ack_i && !service_done_i |=> $stable(cpu_priority_level_o); endproperty
    a_ipl_ro: assert property (p_ipl_ro) else $error("level changed");
    property p_ipl_wr; !nesting_disable_i && ipl_wr_i && !ack_i && !service_done_i |=> cpu_priority_level_o == $past(ipl_val_i); endproperty
    a_ipl_wr: assert property (p_ipl_wr) else $error("level not written");
    // Plain fetch from vector space raises the address error
    property p_vec_fetch; fetch_valid_i && !vector_fetch_i && fetch_pc_i inside {[24'h000004:24'h0000FE]} |=> trap_flags_o[2]; endproperty
    a_vec_fetch: assert property (p_vec_fetch) else $error("no address trap");
    c_take: cover property (ack_i && irq_o);
    c_timed_disable: cover property ($past(timed_disable_active_o) && $rose(irq_o));
    c_trap: cover property ($rose(trap_flags_o[2]));
endmodule // ipc_ctrl_chk
bind ipc_ctrl ipc_ctrl_chk #(.NSRC(NSRC)) i_ipc_ctrl_chk (.*);

// *** test/ipc_core_model.sv ***
// Core-side partner: takes presented requests after a chosen wait
`timescale 1ns/100ps
module ipc_core_model (
    input  wire       core_clk_i,
    input  wire       nrst_i,
    input  wire       irq_i,      // Request presented
    input  wire       pc_load_i,  // Vector load done
    input  wire [1:0] dly_i,      // Cycles to wait before taking
    output reg        ack_o
);
    reg [1:0] seen_reg;  // Cycles the request has stood
    reg       busy_reg;  // Taken request still owes its load
    // One request at a time; changes only at the falling edge
    always @(negedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {ack_o, seen_reg, busy_reg} <= '0;
        end else begin
            ack_o <= 1'b0;
            if (pc_load_i) busy_reg <= 1'b0;
            if (!irq_i || ack_o || busy_reg) seen_reg <= 2'h0;
            else if (seen_reg == dly_i) {ack_o, busy_reg} <= 2'h3;
            else seen_reg <= seen_reg + 2'h1;
        end
    end
endmodule // ipc_core_model

// *** test/ipc_ctrl_bench.sv ***
// Self-checking bench for the interrupt priority controller
`timescale 1ns/100ps
module ipc_ctrl_bench;
    reg         core_clk_i = '0, nrst_i = '0, pri_wr_i = '0, ipl_wr_i = '0, nesting_disable_i = '0;
    reg         alt_table_sel_i = '0, timed_disable_start_i = '0, instr_retire_i = '0, service_done_i = '0;
    reg         fetch_valid_i = '0, vector_fetch_i = '0, goto_valid_i = '0, vec_wr_i = '0;
    reg  [53:0] src_event_i = '0, flag_clr_i = '0, enable_i = '0;
    reg  [23:0] fetch_pc_i = '0, goto_target_i = '0, vec_wr_data_i = '0;
    reg  [13:0] timed_disable_count_i = '0;
    reg  [6:0]  vec_wr_addr_i = '0;
    reg  [5:0]  pri_idx_i = '0;
    reg  [3:0]  ipl_val_i = '0, trap_event_i = '0, trap_clr_i = '0;
    reg  [2:0]  pri_val_i = '0;
    reg  [1:0]  dly = '0;   // Partner wait
    wire [53:0] flags_o;
    wire [23:0] pc_vector_o;
    wire [5:0]  irq_num_o;
    wire [3:0]  cpu_priority_level_o, trap_flags_o, irq_lvl_o;
    wire        timed_disable_active_o, irq_o, pc_load_o, ack_i;
    int         err_count = 0, checked = 0, served = 0, n = 0;
    reg  [23:0] owed[$];    // Vector addresses owed, oldest first
    ipc_ctrl i_ipc_ctrl (.*);
    ipc_core_model i_ipc_core_model (.core_clk_i, .nrst_i, .irq_i(irq_o), .pc_load_i(pc_load_o), .dly_i(dly),
                                     .ack_o(ack_i));
    initial begin
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    // Compare and count
    task chk(input [23:0] s, input [23:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // Next falling edge, where inputs change
    task tick;
        @(negedge core_clk_i);
        instr_retire_i = $urandom % 2;
    endtask
    task setp(input [5:0] i, input [2:0] v);
        tick;
        {pri_wr_i, pri_idx_i, pri_val_i} = {1'b1, i, v};
        tick;
        pri_wr_i = 0;
    endtask
    task cpu_priority_level(input [3:0] v);
        tick;
        {ipl_wr_i, ipl_val_i} = {1'b1, v};
        tick;
        ipl_wr_i = 0;
    endtask
    // Pulse events, note the owed vector, wait for its load or its absence
    task run(input [53:0] ev, input [6:0] ea, input want);
        int k;
        k = served;
        dly = $urandom % 4;
        if (want) owed.push_back({17'h14A00, ea});
        src_event_i = ev;
        tick;
        {src_event_i, fetch_valid_i, goto_valid_i, trap_event_i} = '0;
        repeat (24) if (served == k) tick;
        chk(24'(served - k), 24'(want));
    endtask
    // End service, clear all flags, CPU level back to zero
    task fin(input string s);
        {flag_clr_i, trap_clr_i, service_done_i, nesting_disable_i} = {{58{1'b1}}, 2'h2};
        tick;
        {flag_clr_i, trap_clr_i, service_done_i} = '0;
        cpu_priority_level(4'h0);
        $display("test %s finished", s);
    endtask
    // Each vector load against the oldest owed address
    always @(posedge core_clk_i) begin
        if (pc_load_o === 1'b1) begin
            chk(pc_vector_o, owed.size() ? owed.pop_front() : 24'hXXXXXX);
            served++;
        end
    end
    task print_verdict;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #100000;
        err_count++;
        print_verdict;
    end
    initial begin
        $urandom(44323);
        repeat (12) tick;
        nrst_i = 1;
        tick;
        chk(24'({|flags_o, cpu_priority_level_o, irq_o, pc_load_o, trap_flags_o}), 24'h0);
        for (n = 0; n < 128; n++) begin
            {vec_wr_i, vec_wr_addr_i, vec_wr_data_i} = {1'b1, n[6:0], 17'h14A00, n[6:0]};
            tick;
        end
        {vec_wr_i, enable_i} = {1'b0, ~54'h0};
        repeat (8) begin
            n = $urandom % 41;
            alt_table_sel_i = $urandom % 2;
            setp(n, 1 + $urandom % 7);
            run(54'h1 << n, {alt_table_sel_i, 6'(n + 8)}, 1);
            fin("random");
        end
        alt_table_sel_i = 0;
        enable_i[5] = 0;
        setp(6'h05, 3'h3);
        run(54'h20, 7'h0D, 0);
        chk(flags_o[5], 24'h1);
        enable_i[5] = 1;
        run(54'h0, 7'h0D, 1);
        fin("enable");
        setp(6'h06, 3'h0);
        run(54'h40, 7'h0E, 0);
        fin("level zero");
        // tie goes to the lower number
        setp(6'h02, 3'h5);
        setp(6'h09, 3'h5);
        run(54'h204, 7'h0A, 1);
        fin("tie");
        setp(6'h09, 3'h6);
        run(54'h204, 7'h11, 1);
        fin("level wins");
        cpu_priority_level(4'h5);
        chk(cpu_priority_level_o, 24'h5);
        setp(6'h03, 3'h5);
        run(54'h8, 7'h0B, 0);
        fin("cpu level");
        nesting_disable_i = 1;
        setp(6'h00, 3'h3);
        run(54'h1, 7'h08, 1);
        cpu_priority_level(4'h0);
        chk(cpu_priority_level_o, 24'h3);
        setp(6'h01, 3'h7);
        run(54'h2, 7'h09, 0);
        fin("nesting");
        {timed_disable_start_i, timed_disable_count_i} = {1'b1, 14'h12C};
        tick;
        timed_disable_start_i = 0;
        // level six held off, seven passes
        setp(6'h04, 3'h6);
        run(54'h10, 7'h0C, 0);
        chk(timed_disable_active_o, 24'h1);
        fin("timed disable");
        setp(6'h04, 3'h7);
        run(54'h10, 7'h0C, 1);
        fin("timed disable top");
        // trap served from its own vector
        trap_event_i = 4'h1;
        run(54'h0, 7'h01, 1);
        fin("trap");
        {fetch_valid_i, fetch_pc_i} = {1'b1, 24'h000004 + 24'($urandom % 126) * 24'h2};
        run(54'h0, 7'h03, 1);
        chk(trap_flags_o[2], 24'h1);
        fin("vector fetch");
        {goto_valid_i, goto_target_i} = {1'b1, 24'h0000FE};
        run(54'h0, 7'h03, 1);
        chk(trap_flags_o[2], 24'h1);
        fin("vector jump");
        {fetch_valid_i, vector_fetch_i, fetch_pc_i} = {2'h3, 24'h000010};
        run(54'h0, 7'h03, 0);
        fin("vector read");
        print_verdict;
    end
endmodule // ipc_ctrl_bench
